// ==== core/lpmc_consts.vh ====
// constants for the low-power mode controller
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH

// software mode requests
`define LPMC_REQ_W          3
`define LPMC_REQ_NONE       3'h0
`define LPMC_REQ_SLEEP      3'h1
`define LPMC_REQ_LP_RUN     3'h2
`define LPMC_REQ_LP_SLEEP   3'h3
`define LPMC_REQ_STOP0      3'h4
`define LPMC_REQ_STOP1      3'h5
`define LPMC_REQ_STANDBY    3'h6
`define LPMC_REQ_RUN        3'h7

// mode encodings shown on o_mode
`define LPMC_MODE_RUN       3'h0
`define LPMC_MODE_SLEEP     3'h1
`define LPMC_MODE_LP_RUN    3'h2
`define LPMC_MODE_LP_SLEEP  3'h3
`define LPMC_MODE_STOP0     3'h4
`define LPMC_MODE_STOP1     3'h5
`define LPMC_MODE_STANDBY   3'h6

// pull selection per pin
`define LPMC_PULL_NONE      2'h0
`define LPMC_PULL_UP        2'h1
`define LPMC_PULL_DOWN      2'h2

// timing
`define LPMC_CLK_HZ         25000000
`define LPMC_LP_CPU_HZ      2000000

`endif

// ==== core/lpmc_sync.v ====
// three-stage synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module lpmc_sync #(
    parameter W = 1
) (
    input  wire         i_clock,
    input  wire         i_reset,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_sync
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer     k;

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            s1_r   <= {W{1'b0}};
            s2_r   <= {W{1'b0}};
            s3_r   <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (k = 0; k < W; k = k + 1) begin
                if (s2_r[k] == s3_r[k]) begin
                    o_sync[k] <= s3_r[k];
                end
            end
        end
    end

endmodule // lpmc_sync

`default_nettype wire

// ==== core/lpmc_ctrl.v ====
// low-power mode controller: mode sequencing, supplies, clocks, standby exit
//
// Contract
// - after any reset the mode is Run; low-power modes only on software request
// - Sleep stops only CPU clock; peripherals run; interrupt or event wakes
// - low-power run uses low-power regulator; CPU clock capped at 2 MHz
// - low-power run lets independent-clock peripherals use internal fast oscillator
// - low-power sleep only from low-power run; stops CPU; wakes back
// - main regulator in Run and Sleep; low-power regulator otherwise except Standby
// - Stop halts core clocks, PLL and fast oscillators; keeps low-speed and retention
// - wakeup-capable peripheral may request internal fast oscillator in Stop
// - main regulator stays on in Stop 0, off in Stop 1
// - Standby powers down both regulators (high-z) and PLL and fast oscillators
// - real-time clock may stay active in Stop and Standby by software option
// - Standby applies software-chosen pull-up, pull-down or none per I/O
// - entering Standby loses registers except real-time clock and standby logic
// - Standby exits on reset pin, watchdog, wakeup pin edge, clock, tamper, crystal fail
// - supply threshold reset active in every mode; holds reset while supply low
// - Schmitt-trigger inputs disabled during reset and at its release
// - internal reset source disables the reset pin pull-up
// - backup supply from main while main valid, else battery
// - battery charging allowed only while main supply valid
// - in battery-only operation interrupts and clock events do not cause exit; only Stop and Standby exit is gated, both sleep modes still wake
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.vh"

module lpmc_ctrl #(
    parameter N_IO     = 8,
    parameter N_WAKEUP_PIN   = 4,
    parameter CLK_HZ   = `LPMC_CLK_HZ,
    parameter LP_HZ    = `LPMC_LP_CPU_HZ
) (
    input  wire                   i_clock,
    input  wire                   i_reset,
    // software side
    input  wire [2:0]             i_mode_req,
    input  wire                   i_mode_req_valid,
    input  wire                   i_rtc_keep_en,
    input  wire [2*N_IO-1:0]      i_standby_pull,
    input  wire [N_WAKEUP_PIN-1:0]      i_wakeup_pin_en,
    input  wire [N_WAKEUP_PIN-1:0]      i_wakeup_pin_falling,
    input  wire                   i_charge_req,
    // wake and reset sources
    input  wire                   i_irq_or_event,
    input  wire                   i_stop_wake,
    input  wire                   i_periph_osc_req,
    input  wire                   i_external_reset_pin,
    input  wire                   i_independent_watchdog_rst,
    input  wire [N_WAKEUP_PIN-1:0]      i_wakeup_pin,
    input  wire                   i_rtc_event,
    input  wire                   i_tamper_unit_event,
    input  wire                   i_clock_failure_monitor_lse,
    input  wire                   i_supply_threshold_ok,
    input  wire                   i_internal_reset_src,
    input  wire                   i_main_supply_valid,
    input  wire                   i_battery_supply_valid,
    // mode and control outputs
    output reg  [2:0]             o_mode,
    output reg                    o_main_regulator_on,
    output reg                    o_low_power_regulator_on,
    output reg                    o_regulator_hiz,
    output reg                    o_cpu_clk_en,
    output reg                    o_cpu_clk_tick,
    output reg                    o_core_clk_en,
    output reg                    o_pll_en,
    output reg                    o_internal_fast_osc_en,
    output reg                    o_external_fast_osc_en,
    output reg                    o_periph_fast_osc_sel,
    output reg                    o_low_speed_osc_en,
    output reg                    o_rtc_en,
    output reg                    o_retain,
    output reg                    o_core_domain_rst,
    output reg  [N_IO-1:0]        o_io_pull_up,
    output reg  [N_IO-1:0]        o_io_pull_down,
    output reg                    o_schmitt_en,
    output reg                    o_reset_pin_pullup_en,
    output reg                    o_system_reset,
    output reg                    o_backup_from_main,
    output reg                    o_charge_en,
    output reg                    o_battery_only
);

    // ----------------------------------------------------------------
    // clock divider for low-power CPU rate
    // ----------------------------------------------------------------
    localparam integer DIV_N = (CLK_HZ + LP_HZ - 1) / LP_HZ;
    localparam integer DIV_M1 = DIV_N - 1;
    localparam [7:0]   DIV_LAST = DIV_M1[7:0];

    reg  [7:0] div_r;
    wire       div_tick = (div_r == DIV_LAST);

    function is_low;
        input [2:0] m;
        begin
            is_low = (m == `LPMC_MODE_LP_RUN) || (m == `LPMC_MODE_LP_SLEEP);
        end
    endfunction

    // ----------------------------------------------------------------
    // synchronised pin inputs
    // ----------------------------------------------------------------
    localparam SW = N_WAKEUP_PIN + 9;
    wire [SW-1:0] raw_in = {i_wakeup_pin, i_external_reset_pin, i_independent_watchdog_rst,
                            i_rtc_event, i_tamper_unit_event, i_clock_failure_monitor_lse,
                            i_supply_threshold_ok, i_main_supply_valid,
                            i_battery_supply_valid, i_internal_reset_src};
    wire [SW-1:0] syn;

    lpmc_sync #(.W(SW)) u_sync (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_async (raw_in),
        .o_sync  (syn)
    );

    wire [N_WAKEUP_PIN-1:0] wk_s   = syn[SW-1:9];
    wire              external_reset_pin_s = syn[8];
    wire              independent_watchdog_s = syn[7];
    wire              rtc_s  = syn[6];
    wire              tamper_unit_s = syn[5];
    wire              css_s  = syn[4];
    wire              supok_s = syn[3];
    wire              main_s = syn[2];
    wire              bat_s  = syn[1];
    wire              intr_s = syn[0];

    reg  [N_WAKEUP_PIN-1:0] wk_prev_r;
    wire [N_WAKEUP_PIN-1:0] wk_rise = wk_s & ~wk_prev_r;
    wire [N_WAKEUP_PIN-1:0] wk_fall = ~wk_s & wk_prev_r;
    wire [N_WAKEUP_PIN-1:0] wk_edge = i_wakeup_pin_en &
                                ((wk_rise & ~i_wakeup_pin_falling) |
                                 (wk_fall & i_wakeup_pin_falling));

    // ----------------------------------------------------------------
    // supplies
    // ----------------------------------------------------------------
    wire batt_only = ~main_s & bat_s;
    wire sys_rst   = ~supok_s;
    wire stby_exit = (~external_reset_pin_s) | independent_watchdog_s | (|wk_edge) |
                     (i_rtc_keep_en & rtc_s) | tamper_unit_s | css_s;

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    reg [2:0] mode_r;
    reg [2:0] mode_nxt;

    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            `LPMC_MODE_RUN: begin
                if (i_mode_req_valid) begin
                    case (i_mode_req)
                        `LPMC_REQ_SLEEP:   mode_nxt = `LPMC_MODE_SLEEP;
                        `LPMC_REQ_LP_RUN:  mode_nxt = `LPMC_MODE_LP_RUN;
                        `LPMC_REQ_STOP0:   mode_nxt = `LPMC_MODE_STOP0;
                        `LPMC_REQ_STOP1:   mode_nxt = `LPMC_MODE_STOP1;
                        `LPMC_REQ_STANDBY: mode_nxt = `LPMC_MODE_STANDBY;
                        default:           mode_nxt = mode_r;
                    endcase
                end
            end
            `LPMC_MODE_SLEEP: begin
                if (i_irq_or_event) begin
                    mode_nxt = `LPMC_MODE_RUN;
                end
            end
            `LPMC_MODE_LP_RUN: begin
                if (i_mode_req_valid) begin
                    case (i_mode_req)
                        `LPMC_REQ_LP_SLEEP: mode_nxt = `LPMC_MODE_LP_SLEEP;
                        `LPMC_REQ_RUN:      mode_nxt = `LPMC_MODE_RUN;
                        `LPMC_REQ_STOP0:    mode_nxt = `LPMC_MODE_STOP0;
                        `LPMC_REQ_STOP1:    mode_nxt = `LPMC_MODE_STOP1;
                        `LPMC_REQ_STANDBY:  mode_nxt = `LPMC_MODE_STANDBY;
                        default:            mode_nxt = mode_r;
                    endcase
                end
            end
            `LPMC_MODE_LP_SLEEP: begin
                if (i_irq_or_event) begin
                    mode_nxt = `LPMC_MODE_LP_RUN;
                end
            end
            `LPMC_MODE_STOP0, `LPMC_MODE_STOP1: begin
                if (i_stop_wake && !batt_only) begin
                    mode_nxt = `LPMC_MODE_RUN;
                end
            end
            `LPMC_MODE_STANDBY: begin
                if (stby_exit && !batt_only) begin
                    mode_nxt = `LPMC_MODE_RUN;
                end
            end
            default: mode_nxt = `LPMC_MODE_RUN;
        endcase
    end

    wire stby_leave = (mode_r == `LPMC_MODE_STANDBY) &&
                      (mode_nxt == `LPMC_MODE_RUN);

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            mode_r    <= `LPMC_MODE_RUN;
            div_r     <= 8'h00;
            wk_prev_r <= {N_WAKEUP_PIN{1'b0}};
        end else begin
            wk_prev_r <= wk_s;
            if (sys_rst) begin
                mode_r <= `LPMC_MODE_RUN;
            end else begin
                mode_r <= mode_nxt;
            end
            if (div_tick) begin
                div_r <= 8'h00;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs per mode
    // ----------------------------------------------------------------
    integer j;
    reg     rst_d1_r;

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_mode                   <= `LPMC_MODE_RUN;
            o_main_regulator_on      <= 1'b1;
            o_low_power_regulator_on <= 1'b0;
            o_regulator_hiz          <= 1'b0;
            o_cpu_clk_en             <= 1'b0;
            o_cpu_clk_tick           <= 1'b0;
            o_core_clk_en            <= 1'b0;
            o_pll_en                 <= 1'b0;
            o_internal_fast_osc_en   <= 1'b1;
            o_external_fast_osc_en   <= 1'b0;
            o_periph_fast_osc_sel    <= 1'b0;
            o_low_speed_osc_en       <= 1'b1;
            o_rtc_en                 <= 1'b1;
            o_retain                 <= 1'b1;
            o_core_domain_rst        <= 1'b1;
            o_io_pull_up             <= {N_IO{1'b0}};
            o_io_pull_down           <= {N_IO{1'b0}};
            o_schmitt_en             <= 1'b0;
            o_reset_pin_pullup_en    <= 1'b1;
            o_system_reset           <= 1'b1;
            rst_d1_r                 <= 1'b1;
            o_backup_from_main       <= 1'b0;
            o_charge_en              <= 1'b0;
            o_battery_only           <= 1'b0;
        end else begin
            o_mode         <= mode_r;
            o_system_reset <= sys_rst | stby_leave;
            rst_d1_r       <= o_system_reset;
            o_schmitt_en   <= ~sys_rst & ~stby_leave & ~o_system_reset & ~rst_d1_r;
            o_reset_pin_pullup_en <= ~intr_s;
            o_backup_from_main    <= main_s;
            o_battery_only        <= batt_only;
            o_charge_en    <= i_charge_req & main_s;
            o_low_speed_osc_en <= 1'b1;
            o_regulator_hiz    <= 1'b0;
            o_retain           <= 1'b1;
            o_core_domain_rst  <= 1'b0;
            o_periph_fast_osc_sel <= 1'b0;
            o_rtc_en           <= 1'b1;
            o_io_pull_up       <= {N_IO{1'b0}};
            o_io_pull_down     <= {N_IO{1'b0}};
            o_cpu_clk_tick     <= 1'b1;
            case (mode_r)
                `LPMC_MODE_RUN, `LPMC_MODE_SLEEP: begin
                    o_main_regulator_on      <= 1'b1;
                    o_low_power_regulator_on <= 1'b0;
                    o_cpu_clk_en   <= (mode_r == `LPMC_MODE_RUN);
                    o_core_clk_en  <= 1'b1;
                    o_pll_en       <= 1'b1;
                    o_internal_fast_osc_en <= 1'b1;
                    o_external_fast_osc_en <= 1'b1;
                end
                `LPMC_MODE_LP_RUN, `LPMC_MODE_LP_SLEEP: begin
                    o_main_regulator_on      <= 1'b0;
                    o_low_power_regulator_on <= 1'b1;
                    o_cpu_clk_en   <= (mode_r == `LPMC_MODE_LP_RUN);
                    o_cpu_clk_tick <= div_tick & is_low(mode_r);
                    o_core_clk_en  <= 1'b1;
                    o_pll_en       <= 1'b0;
                    o_internal_fast_osc_en <= 1'b1;
                    o_periph_fast_osc_sel  <= 1'b1;
                    o_external_fast_osc_en <= 1'b0;
                end
                `LPMC_MODE_STOP0, `LPMC_MODE_STOP1: begin
                    o_main_regulator_on <= (mode_r == `LPMC_MODE_STOP0);
                    o_low_power_regulator_on <= 1'b1;
                    o_cpu_clk_en   <= 1'b0;
                    o_cpu_clk_tick <= 1'b0;
                    o_core_clk_en  <= 1'b0;
                    o_pll_en       <= 1'b0;
                    o_internal_fast_osc_en <= i_periph_osc_req;
                    o_external_fast_osc_en <= 1'b0;
                    o_rtc_en       <= i_rtc_keep_en;
                end
                `LPMC_MODE_STANDBY: begin
                    o_main_regulator_on      <= 1'b0;
                    o_low_power_regulator_on <= 1'b0;
                    o_regulator_hiz          <= 1'b1;
                    o_cpu_clk_en   <= 1'b0;
                    o_cpu_clk_tick <= 1'b0;
                    o_core_clk_en  <= 1'b0;
                    o_pll_en       <= 1'b0;
                    o_internal_fast_osc_en <= 1'b0;
                    o_external_fast_osc_en <= 1'b0;
                    o_rtc_en       <= i_rtc_keep_en;
                    o_retain       <= 1'b0;
                    o_core_domain_rst <= 1'b1;
                    for (j = 0; j < N_IO; j = j + 1) begin
                        o_io_pull_up[j]   <= (i_standby_pull[2*j +: 2] == `LPMC_PULL_UP);
                        o_io_pull_down[j] <= (i_standby_pull[2*j +: 2] == `LPMC_PULL_DOWN);
                    end
                end
                default: begin
                    o_main_regulator_on      <= 1'b1;
                    o_low_power_regulator_on <= 1'b0;
                    o_cpu_clk_en   <= 1'b0;
                    o_core_clk_en  <= 1'b0;
                    o_pll_en       <= 1'b0;
                    o_internal_fast_osc_en <= 1'b1;
                    o_external_fast_osc_en <= 1'b0;
                end
            endcase
        end
    end

endmodule // lpmc_ctrl

`default_nettype wire

// ==== verif/lpmc_ctrl_props.sv ====
// checker for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.vh"
module lpmc_props (
    input wire logic       i_clock,
    input wire logic       i_reset,
    input wire logic [2:0] i_mode_req,
    input wire logic       i_mode_req_valid,
    input wire logic       i_stop_wake,
    input wire logic [2:0] o_mode,
    input wire logic       o_main_regulator_on,
    input wire logic       o_low_power_regulator_on,
    input wire logic       o_regulator_hiz,
    input wire logic       o_cpu_clk_en,
    input wire logic       o_cpu_clk_tick,
    input wire logic       o_core_clk_en,
    input wire logic       o_pll_en,
    input wire logic       o_internal_fast_osc_en,
    input wire logic       o_external_fast_osc_en,
    input wire logic       o_low_speed_osc_en,
    input wire logic       o_retain,
    input wire logic       o_schmitt_en,
    input wire logic       o_system_reset,
    input wire logic       o_charge_en,
    input wire logic       o_battery_only
);
    wire stp = (o_mode == `LPMC_MODE_STOP0) || (o_mode == `LPMC_MODE_STOP1);
    wire lp  = (o_mode == `LPMC_MODE_LP_RUN) || (o_mode == `LPMC_MODE_LP_SLEEP);
    wire hi  = (o_mode == `LPMC_MODE_RUN) || (o_mode == `LPMC_MODE_SLEEP);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    a_stop_clk_off: assert property (stp |-> !o_core_clk_en && !o_pll_en && !o_cpu_clk_en
        && !o_external_fast_osc_en && o_low_speed_osc_en && o_retain)
        else $error("clock or oscillator on in stop");
    a_reg_main_hi: assert property (hi |-> o_main_regulator_on && !o_low_power_regulator_on)
        else $error("wrong regulator in run or sleep");
    a_reg_lp_used: assert property ((lp || stp) |-> o_low_power_regulator_on)
        else $error("low-power regulator off");
    a_stop_main_reg: assert property (stp |-> o_main_regulator_on == (o_mode == `LPMC_MODE_STOP0))
        else $error("main regulator wrong in stop");
    a_standby_off: assert property (o_mode == `LPMC_MODE_STANDBY |-> o_regulator_hiz && !o_pll_en
        && !o_main_regulator_on && !o_low_power_regulator_on && !o_external_fast_osc_en)
        else $error("supply or oscillator on in standby");
    a_sleep_cpu_off: assert property ((o_mode == `LPMC_MODE_SLEEP) || (o_mode == `LPMC_MODE_LP_SLEEP)
        |-> !o_cpu_clk_en && (o_core_clk_en || lp))
        else $error("cpu clock on in sleep");
    a_lp_tick_gap: assert property (o_cpu_clk_tick && o_mode == `LPMC_MODE_LP_RUN
        |=> (!o_cpu_clk_tick || hi)[*8])
        else $error("cpu tick too fast");
    a_lp_sleep_from: assert property ($changed(o_mode) && o_mode == `LPMC_MODE_LP_SLEEP
        |-> $past(o_mode) == `LPMC_MODE_LP_RUN)
        else $error("low-power sleep entered from wrong mode");
    a_req_taken: assert property (i_mode_req_valid && i_mode_req == `LPMC_REQ_STOP0 && !o_system_reset
        && o_mode == `LPMC_MODE_RUN && $past(!i_mode_req_valid) |-> ##2 o_mode == `LPMC_MODE_STOP0)
        else $error("stop request not taken");
    a_stop_wake_run: assert property (stp && i_stop_wake && !o_battery_only
        |-> ##2 o_mode == `LPMC_MODE_RUN && o_core_clk_en && o_main_regulator_on)
        else $error("stop wake did not return to run");
    a_charge_main: assert property (o_charge_en |-> !o_battery_only)
        else $error("charging without main supply");
    a_schmitt_rst: assert property (o_system_reset |=> !o_schmitt_en[*2])
        else $error("schmitt inputs on around reset");
endmodule // lpmc_props
bind lpmc_ctrl lpmc_props lpmc_props_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_mode_req(i_mode_req), .i_mode_req_valid(i_mode_req_valid), .i_stop_wake(i_stop_wake),
    .o_mode(o_mode), .o_main_regulator_on(o_main_regulator_on),
    .o_low_power_regulator_on(o_low_power_regulator_on), .o_regulator_hiz(o_regulator_hiz),
    .o_cpu_clk_en(o_cpu_clk_en), .o_cpu_clk_tick(o_cpu_clk_tick), .o_core_clk_en(o_core_clk_en),
    .o_pll_en(o_pll_en), .o_internal_fast_osc_en(o_internal_fast_osc_en),
    .o_external_fast_osc_en(o_external_fast_osc_en), .o_low_speed_osc_en(o_low_speed_osc_en),
    .o_retain(o_retain), .o_schmitt_en(o_schmitt_en), .o_system_reset(o_system_reset),
    .o_charge_en(o_charge_en), .o_battery_only(o_battery_only));
`default_nettype wire

// ==== verif/lpmc_partner.sv ====
// far-side model: cpu interrupt and stop wake sources
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.vh"
module lpmc_partner (
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    input  wire logic [2:0] i_mode,
    input  wire logic       i_en,
    input  wire logic [7:0] i_delay,
    output var  logic       o_irq_or_event,
    output var  logic       o_stop_wake
);
    logic [7:0] cnt_r;
    logic       done_r;
    wire slp = (i_mode == `LPMC_MODE_SLEEP) || (i_mode == `LPMC_MODE_LP_SLEEP);
    wire stp = (i_mode == `LPMC_MODE_STOP0) || (i_mode == `LPMC_MODE_STOP1);
    // one wake pulse per waiting period, after a set delay
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            cnt_r <= 8'h00;
            done_r <= 1'b0;
            o_irq_or_event <= 1'b0;
            o_stop_wake <= 1'b0;
        end else begin
            o_irq_or_event <= 1'b0;
            o_stop_wake <= 1'b0;
            if (!(slp || stp) || !i_en) begin
                cnt_r <= 8'h00;
                done_r <= 1'b0;
            end else if (!done_r && cnt_r == i_delay) begin
                o_irq_or_event <= slp;
                o_stop_wake <= stp;
                done_r <= 1'b1;
            end else if (!done_r) begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule // lpmc_partner
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.vh"
module testbench;
    logic        clk, rst, vld, rtck, chg, preq, sup, isrc, mv, bv, pen, irq, swk, pfs, cdr;
    logic [2:0]  req, mode;
    logic [5:0]  sv;
    logic [7:0]  dly, pu, pd;
    logic        mreg, lreg, hiz, cpu, tick, core, ifo, rtc, sch, rpu, sysr, bfm, chen, bo;
    int          checks, miscompares;
    lpmc_ctrl lpmc_ctrl_inst (.i_clock(clk), .i_reset(rst), .i_mode_req(req),
        .i_mode_req_valid(vld), .i_rtc_keep_en(rtck), .i_standby_pull(16'h0009),
        .i_wakeup_pin_en(4'h1), .i_wakeup_pin_falling(4'h0), .i_charge_req(chg),
        .i_irq_or_event(irq), .i_stop_wake(swk), .i_periph_osc_req(preq),
        .i_external_reset_pin(~sv[5]), .i_independent_watchdog_rst(sv[3]),
        .i_wakeup_pin({3'h0, sv[0]}), .i_rtc_event(sv[4]), .i_tamper_unit_event(sv[1]),
        .i_clock_failure_monitor_lse(sv[2]), .i_supply_threshold_ok(sup),
        .i_internal_reset_src(isrc), .i_main_supply_valid(mv), .i_battery_supply_valid(bv),
        .o_mode(mode), .o_main_regulator_on(mreg), .o_low_power_regulator_on(lreg),
        .o_regulator_hiz(hiz), .o_cpu_clk_en(cpu), .o_cpu_clk_tick(tick),
        .o_core_clk_en(core), .o_pll_en(), .o_internal_fast_osc_en(ifo),
        .o_external_fast_osc_en(), .o_periph_fast_osc_sel(pfs), .o_low_speed_osc_en(),
        .o_rtc_en(rtc), .o_retain(), .o_core_domain_rst(cdr), .o_io_pull_up(pu),
        .o_io_pull_down(pd), .o_schmitt_en(sch), .o_reset_pin_pullup_en(rpu),
        .o_system_reset(sysr), .o_backup_from_main(bfm), .o_charge_en(chen), .o_battery_only(bo));
    lpmc_partner lpmc_partner_inst (.i_clock(clk), .i_reset(rst), .i_mode(mode), .i_en(pen),
        .i_delay(dly), .o_irq_or_event(irq), .o_stop_wake(swk));
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task rq(input logic [2:0] c);
        @(posedge clk);
        req <= c;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        w(3);
    endtask
    task wm(input logic [2:0] e);
        int i;
        for (i = 0; i < 80 && mode !== e; i++) w(1);
        chk("mode", mode, e);
    endtask
    task t_lp;
        logic [15:0] n;
        n = 0;
        rq(`LPMC_REQ_LP_SLEEP);
        chk("mode", mode, `LPMC_MODE_RUN);
        rq(`LPMC_REQ_LP_RUN);
        chk("lpreg", {mreg, lreg, pfs}, 3'h3);
        repeat (130) begin
            w(1);
            n = n + tick;
        end
        chk("ticks", n, 16'h000a);
        rq(`LPMC_REQ_LP_SLEEP);
        chk("cpu", {mode, cpu}, {`LPMC_MODE_LP_SLEEP, 1'b0});
        wm(`LPMC_MODE_LP_RUN);
        rq(`LPMC_REQ_RUN);
        rq(`LPMC_REQ_SLEEP);
        chk("sleep", {mode, cpu, core, mreg}, {`LPMC_MODE_SLEEP, 3'h3});
        wm(`LPMC_MODE_RUN);
        $display("t_lp done");
    endtask
    task t_stop;
        int i;
        dly <= 8'h28;
        for (i = 0; i < 2; i++) begin
            rq(i ? `LPMC_REQ_STOP1 : `LPMC_REQ_STOP0);
            chk("stop", {mode, mreg, core, ifo}, {i ? 3'h5 : 3'h4, i == 0, 2'h0});
            @(posedge clk) preq <= 1'b1;
            w(2);
            chk("ifo", ifo, 1'b1);
            @(posedge clk) preq <= 1'b0;
            wm(`LPMC_MODE_RUN);
            chk("back", {core, mreg}, 2'h3);
        end
        $display("t_stop done");
    endtask
    task t_batt;
        @(posedge clk) chg <= 1'b1;
        w(8);
        chk("chg", {chen, bfm}, 2'h3);
        pen <= 1'b0;
        rq(`LPMC_REQ_STOP1);
        @(posedge clk) mv <= 1'b0;
        w(8);
        chk("bat", {bo, bfm, chen}, 3'h4);
        @(posedge clk) pen <= 1'b1;
        w(60);
        chk("mode", mode, `LPMC_MODE_STOP1);
        @(posedge clk) mv <= 1'b1;
        pen <= 1'b0;
        chg <= 1'b0;
        @(posedge clk) pen <= 1'b1;
        wm(`LPMC_MODE_RUN);
        $display("t_batt done");
    endtask
    task t_stby;
        int s;
        @(posedge clk) rtck <= 1'b1;
        for (s = 0; s < 6; s++) begin
            rq(`LPMC_REQ_STANDBY);
            chk("stby", {mode, hiz, mreg, lreg, rtc}, {`LPMC_MODE_STANDBY, 4'h9});
            chk("pulls", {pu, pd}, 16'h0102);
            chk("cdr", cdr, 1'b1);
            @(posedge clk) sv <= 6'h01 << s;
            w(8);
            @(posedge clk) sv <= 6'h00;
            w(8);
            wm(`LPMC_MODE_RUN);
        end
        @(posedge clk) isrc <= 1'b1;
        w(8);
        chk("rpu", rpu, 1'b0);
        @(posedge clk) isrc <= 1'b0;
        w(8);
        chk("rpu", rpu, 1'b1);
        $display("t_stby done");
    endtask
    task t_sup;
        rq(`LPMC_REQ_LP_RUN);
        @(posedge clk) sup <= 1'b0;
        w(8);
        chk("sup", {sysr, mode}, {1'b1, `LPMC_MODE_RUN});
        @(posedge clk) sup <= 1'b1;
        w(12);
        chk("rel", {sysr, sch}, 2'h1);
        $display("t_sup done");
    endtask
    task results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        results();
    end
    initial begin
        {rst, vld, rtck, chg, preq, sup, isrc, mv, bv, pen} = 10'h217;
        {req, sv, dly, checks, miscompares} = 0;
        dly = 8'h02;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        w(10);
        chk("init", {mode, sysr, sch}, {`LPMC_MODE_RUN, 2'h1});
        t_lp();
        t_stop();
        t_batt();
        t_stby();
        t_sup();
        results();
    end
endmodule // testbench
`default_nettype wire
